// >>> pkg/cfb_pkg.sv
// Shared constants and types for the CAN filter, buffer, timer and
// error block.
// Assumes an 8-bit register port and a frame engine on the same clock.
package cfb_pkg;
  localparam int NUM_OBJ = 6;
  localparam int OBJ_W = 3;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 8;
  localparam int IDX_W = 3;
  // Register offsets.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_GIT = 5'h01;
  localparam logic [4:0] REG_IE = 5'h02;
  localparam logic [4:0] REG_SIT = 5'h03;
  localparam logic [4:0] REG_HPP = 5'h04;
  localparam logic [4:0] REG_PAGE = 5'h05;
  localparam logic [4:0] REG_STAT = 5'h06;
  localparam logic [4:0] REG_DATA = 5'h07;
  localparam logic [4:0] REG_TAG0 = 5'h08;
  localparam logic [4:0] REG_MSK0 = 5'h0c;
  localparam logic [4:0] REG_STMP_L = 5'h10;
  localparam logic [4:0] REG_STMP_H = 5'h11;
  localparam logic [4:0] REG_TMR_L = 5'h12;
  localparam logic [4:0] REG_TMR_H = 5'h13;
  localparam logic [4:0] REG_PRESC = 5'h14;
  localparam logic [4:0] REG_TEC = 5'h15;
  localparam logic [4:0] REG_REC = 5'h16;
  localparam logic [4:0] REG_ESTAT = 5'h17;
  localparam logic [4:0] REG_OCFG = 5'h18;
  localparam logic [4:0] REG_SYNC_L = 5'h19;
  localparam logic [4:0] REG_SYNC_H = 5'h1a;
  // Control bits.
  localparam int CTRL_EN = 0;
  localparam int CTRL_TTC = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_GIE = 3;
  localparam int CTRL_OVIE = 4;
  // General flag bits; errors occupy GIT_ERR_LO upward.
  localparam int GIT_OVR = 0;
  localparam int GIT_BUS_OFF_STATUS = 1;
  localparam int GIT_BX = 2;
  localparam int GIT_ERR_LO = 3;
  // Object status bits; errors occupy ST_ERR_LO upward.
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_ERR_LO = 2;
  // Error vector order: bit, stuff, crc, form, ack.
  localparam int NUM_ERR = 5;
  localparam int E_BIT = 0;
  localparam int E_FORM = 3;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_ERR = 2;
  localparam int PAGE_AUTO_INCREMENT_DISABLE = 3;
  localparam logic [3:0] HPP_NONE = 4'hf;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int CLK_DIV = 8;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [8:0] TEC_TX_INC = 9'h008;
  localparam logic [8:0] ERR_PASSIVE = 9'h080;
  localparam logic [8:0] ERR_BUSOFF = 9'h100;

  typedef enum logic [1:0] {ERR_ACTIVE, ERR_PASSIVE_ST, BUS_OFF} cfb_fault_e;

  // Identifier tag or mask: extension, remote, reserved and identifier.
  typedef struct packed {
    logic ide;
    logic rtr;
    logic rb;
    logic [28:0] id;
  } cfb_tag_s;

  // Per-bit view of the link from the frame engine.
  typedef struct packed {
    logic strobe;
    logic sent;
    logic seen;
    logic transmitting;
    logic arbOrAck;
    logic errFrame;
    logic stuffCheck;
    logic ackSlot;
  } cfb_bitmon_s;
endpackage : cfb_pkg

// >>> hw/cfb_timer.sv
// Prescaled 16-bit stamp timer for the CAN block.
// Assumes enable is a synchronous level from the register file.
`timescale 1ns/100ps
module cfb_timer #(
  parameter int PRESC_W = 8,
  parameter int TIMER_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [PRESC_W-1:0] prescale,
  output logic [TIMER_W-1:0] count,
  output logic overflow
);
  import cfb_pkg::*;

  localparam int DIV_W = $clog2(CLK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);

  logic [DIV_W-1:0] div;
  logic [PRESC_W-1:0] presc;
  logic tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (!enable) begin
      div <= '0;
    end else begin
      div <= (div == DIV_LAST) ? '0 : div + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= '0;
    end else if (!enable) begin
      presc <= '0;
    end else if (div == DIV_LAST) begin
      presc <= (presc >= prescale) ? '0 : presc + 1'b1;
    end
  end

  assign tick = enable && (div == DIV_LAST) && (presc >= prescale);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      overflow <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= tick && (&count);
      if (tick) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : cfb_timer

// >>> hw/cfb_top.sv
// CAN acceptance filter, object pages, data buffers, stamp timer and
// error confinement, seen by software through an 8-bit register port.
// Assumes a frame engine on sys_clk that delivers identifiers, bytes,
// per-bit monitor data and frame events; no input needs synchronising.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module cfb_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [cfb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cfb_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [cfb_pkg::DATA_W-1:0] regRdData,
  input wire cfb_pkg::cfb_bitmon_s bitMon,
  input wire logic crcMismatch,
  input wire logic formViolation,
  input wire logic otherErrorFrame,
  input wire logic rxIdValid,
  input wire cfb_pkg::cfb_tag_s rxTag,
  input wire logic rxByteValid,
  input wire logic [cfb_pkg::IDX_W-1:0] rxByteIdx,
  input wire logic [cfb_pkg::DATA_W-1:0] rxByte,
  input wire logic rxDone,
  input wire logic txDone,
  input wire logic [cfb_pkg::OBJ_W-1:0] txObj,
  input wire logic [cfb_pkg::IDX_W-1:0] txByteIdx,
  input wire logic sofSeen,
  input wire logic eofSeen,
  input wire logic bufferSetDone,
  input wire logic ovfHandlerEntry,
  output logic [cfb_pkg::DATA_W-1:0] txByte,
  output logic errorFrameReq,
  output logic errorFramePassive,
  output logic busInhibit,
  output logic retryAllowed,
  output logic canIrq,
  output logic timerIrq
);
  import cfb_pkg::*;

  // Lowest set bit of an object vector, with a found flag on top.
  function automatic logic [OBJ_W:0] firstSet(input logic [NUM_OBJ-1:0] v);
    logic [OBJ_W:0] r;
    r = '0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, OBJ_W'(i)};
      end
    end
    return r;
  endfunction : firstSet

  logic [7:0] ctrl;
  logic [7:0] git;
  logic [2:0] irqEn;
  logic [3:0] page;
  logic aincOff;
  logic [IDX_W-1:0] dataIdx;
  logic [7:0] prescale;
  cfb_tag_s tag [NUM_OBJ];
  cfb_tag_s mask [NUM_OBJ];
  logic [NUM_OBJ-1:0] rxArm;
  logic [6:0] stat [NUM_OBJ];
  logic [15:0] stamp [NUM_OBJ];
  logic [7:0] dataBuf [NUM_OBJ][BUF_DEPTH];
  logic matchValid;
  logic [OBJ_W-1:0] matchObj;
  logic [2:0] runLen;
  logic lastSeen;
  logic [8:0] tec;
  logic [8:0] rec;
  cfb_fault_e fault;
  cfb_fault_e next_fault;
  logic [15:0] timerVal;
  logic timerOvf;
  logic [15:0] syncStamp;
  logic [NUM_OBJ-1:0] hitVec;
  logic [OBJ_W:0] hit;
  logic [NUM_OBJ-1:0] sit;
  logic [OBJ_W:0] hpp;
  logic [NUM_ERR-1:0] errVec;
  logic errAny;
  logic objErr;
  logic [OBJ_W-1:0] errObj;
  logic pageOk;
  logic [OBJ_W-1:0] sel;
  logic dataAcc;
  logic [7:0] next_rdData;

  assign pageOk = page < 4'(NUM_OBJ);
  assign sel = page[OBJ_W-1:0];
  assign dataAcc = pageOk && (regWr || regRd) && (regAddr == REG_DATA);

  cfb_timer #(.PRESC_W(8), .TIMER_W(16)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(ctrl[CTRL_EN]),
    .prescale(prescale),
    .count(timerVal),
    .overflow(timerOvf)
  );

  // masked compare, lowest object wins the hit.
  always_comb begin
    for (int i = 0; i < NUM_OBJ; i++) begin
      hitVec[i] = rxArm[i] && (((tag[i] ^ rxTag) & mask[i]) == '0);
    end
    hit = firstSet(hitVec);
  end

  // bit and stuff checks, crc, form and ack, form adds bit when transmitting.
  always_comb begin
    errVec = '0;
    if (bitMon.strobe && bitMon.transmitting &&
        bitMon.sent != bitMon.seen &&
        !(bitMon.sent && !bitMon.seen && bitMon.arbOrAck) &&
        !(bitMon.errFrame && !bitMon.seen)) begin
      errVec[E_BIT] = 1'b1;
    end
    errVec[1] = bitMon.strobe && bitMon.stuffCheck &&
                bitMon.seen == lastSeen && runLen >= STUFF_LIMIT;
    errVec[2] = crcMismatch && !bitMon.transmitting;
    errVec[E_FORM] = formViolation;
    errVec[4] = bitMon.strobe && bitMon.ackSlot &&
                bitMon.transmitting && bitMon.seen;
    if (formViolation && bitMon.transmitting) begin
      errVec[E_BIT] = 1'b1;
    end
    // A node that is bus off takes no part, so its checks are void.
    if (fault == BUS_OFF) begin
      errVec = '0;
    end
    errAny = |errVec;
  end

  // route errors to the object or the general register.
  assign objErr = bitMon.transmitting || matchValid;
  assign errObj = bitMon.transmitting ? txObj : matchObj;

  // run length of equal monitored bits.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runLen <= 3'h1;
      lastSeen <= 1'b1;
    end else if (bitMon.strobe) begin
      lastSeen <= bitMon.seen;
      if (!bitMon.stuffCheck || bitMon.seen != lastSeen) begin
        runLen <= 3'h1;
      end else if (runLen < 3'h7) begin
        runLen <= runLen + 3'h1;
      end
    end
  end

  // Control, enables, prescale and object arming from software.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= REG_RST;
      irqEn <= '0;
      prescale <= REG_RST;
      rxArm <= '0;
    end else if (regWr) begin
      case (regAddr)
        REG_CTRL: ctrl <= {3'h0, regWrData[4:0]};
        REG_IE: irqEn <= regWrData[2:0];
        REG_PRESC: prescale <= regWrData;
        REG_OCFG: begin
          if (pageOk) begin
            rxArm[sel] <= regWrData[0];
          end
        end
        default: ;
      endcase
    end
  end

  // page select, index step and wrap after a data access.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page <= '0;
      aincOff <= 1'b0;
      dataIdx <= '0;
    end else if (regWr && regAddr == REG_PAGE) begin
      page <= regWrData[7:4];
      aincOff <= regWrData[PAGE_AUTO_INCREMENT_DISABLE];
      dataIdx <= regWrData[IDX_W-1:0];
    end else if (dataAcc && !aincOff) begin
      dataIdx <= dataIdx + 1'b1;
    end
  end

  // tags follow a hit; software writes fill tags and masks bytewise.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        tag[i] <= '0;
        mask[i] <= '0;
      end
    end else begin
      if (regWr && pageOk && regAddr[4:2] == REG_TAG0[4:2]) begin
        tag[sel][8*regAddr[1:0] +: 8] <= regWrData;
      end
      if (regWr && pageOk && regAddr[4:2] == REG_MSK0[4:2]) begin
        mask[sel][8*regAddr[1:0] +: 8] <= regWrData;
      end
      if (rxIdValid && hit[OBJ_W]) begin
        tag[hit[OBJ_W-1:0]] <= rxTag;
      end
    end
  end

  // The hit object owns the frame until it completes or fails.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      matchValid <= 1'b0;
      matchObj <= '0;
    end else if (rxIdValid && hit[OBJ_W]) begin
      matchValid <= 1'b1;
      matchObj <= hit[OBJ_W-1:0];
    end else if (rxDone || errAny || otherErrorFrame) begin
      matchValid <= 1'b0;
    end
  end

  // one buffer per object; received bytes land in the hit object.
  always_ff @(posedge sys_clk) begin
    if (regWr && regAddr == REG_DATA && pageOk) begin
      dataBuf[sel][dataIdx] <= regWrData;
    end
    if (rxByteValid && matchValid) begin
      dataBuf[matchObj][rxByteIdx] <= rxByte;
    end
  end

  // Transmit bytes are looked up one cycle after the engine asks.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txByte <= '0;
    end else if (txObj < OBJ_W'(NUM_OBJ)) begin
      txByte <= dataBuf[txObj][txByteIdx];
    end
  end

  // software rewrites status; hardware sets win in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        stat[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        logic [6:0] set;
        set = '0;
        set[ST_RX] = rxDone && matchValid && matchObj == OBJ_W'(i);
        set[ST_TX] = txDone && txObj == OBJ_W'(i);
        if (objErr && errObj == OBJ_W'(i)) begin
          set[ST_ERR_LO +: NUM_ERR] = errVec;
        end
        if (regWr && regAddr == REG_STAT && pageOk && sel == OBJ_W'(i)) begin
          stat[i] <= regWrData[6:0] | set;
        end else begin
          stat[i] <= stat[i] | set;
        end
      end
    end
  end

  // stamp on completion, held until the next completion.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        stamp[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        if ((rxDone && matchValid && matchObj == OBJ_W'(i)) ||
            (txDone && txObj == OBJ_W'(i))) begin
          stamp[i] <= timerVal;
        end
      end
    end
  end

  // sync point capture in time-triggered mode.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncStamp <= '0;
    end else if (ctrl[CTRL_TTC] &&
                 (ctrl[CTRL_SYNC] ? eofSeen : sofSeen)) begin
      syncStamp <= timerVal;
    end
  end

  // error counters; bus off holds them until the channel restarts.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tec <= '0;
      rec <= '0;
    end else if (!ctrl[CTRL_EN]) begin
      tec <= '0;
      rec <= '0;
    end else if (fault != BUS_OFF) begin
      if (errAny && bitMon.transmitting) begin
        tec <= tec + TEC_TX_INC;
      end else if (errAny && rec < ERR_BUSOFF - 9'h001) begin
        rec <= rec + 9'h001;
      end else if (txDone && tec != '0) begin
        tec <= tec - 9'h001;
      end else if (rxDone && matchValid && rec != '0) begin
        rec <= rec - 9'h001;
      end
    end
  end

  // confinement state from the counters; bus off is sticky.
  always_comb begin
    case (fault)
      BUS_OFF: next_fault = ctrl[CTRL_EN] ? BUS_OFF : ERR_ACTIVE;
      ERR_ACTIVE, ERR_PASSIVE_ST: begin
        if (tec >= ERR_BUSOFF) begin
          next_fault = BUS_OFF;
        end else if (tec >= ERR_PASSIVE || rec >= ERR_PASSIVE) begin
          next_fault = ERR_PASSIVE_ST;
        end else begin
          next_fault = ERR_ACTIVE;
        end
      end
      default: next_fault = ERR_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= ERR_ACTIVE;
    end else begin
      fault <= next_fault;
    end
  end

  // write one clears, handler entry also clears overflow.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      git <= REG_RST;
    end else begin
      logic [7:0] set;
      logic [7:0] clr;
      set = '0;
      clr = '0;
      set[GIT_OVR] = timerOvf;
      set[GIT_BUS_OFF_STATUS] = next_fault == BUS_OFF && fault != BUS_OFF;
      set[GIT_BX] = bufferSetDone;
      if (!objErr) begin
        set[GIT_ERR_LO +: NUM_ERR] = errVec;
      end
      if (regWr && regAddr == REG_GIT) begin
        clr = regWrData;
      end
      clr[GIT_OVR] = clr[GIT_OVR] | ovfHandlerEntry;
      git <= (git & ~clr) | set;
    end
  end

  // object interrupt bits need the flag and its enable.
  always_comb begin
    for (int i = 0; i < NUM_OBJ; i++) begin
      sit[i] = (stat[i][ST_RX] && irqEn[IE_RX]) ||
               (stat[i][ST_TX] && irqEn[IE_TX]) ||
               ((|stat[i][ST_ERR_LO +: NUM_ERR]) && irqEn[IE_ERR]);
    end
    hpp = firstSet(sit);
  end

  // no retries in time-triggered mode, error frames, gating.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      retryAllowed <= 1'b1;
      errorFrameReq <= 1'b0;
      errorFramePassive <= 1'b0;
      busInhibit <= 1'b0;
      canIrq <= 1'b0;
      timerIrq <= 1'b0;
    end else begin
      retryAllowed <= !ctrl[CTRL_TTC];
      errorFrameReq <= (errAny || otherErrorFrame) && fault != BUS_OFF;
      errorFramePassive <= fault == ERR_PASSIVE_ST;
      busInhibit <= fault == BUS_OFF;
      canIrq <= ctrl[CTRL_GIE] && ((|sit) || (|git[7:1]));
      timerIrq <= ctrl[CTRL_GIE] && ctrl[CTRL_OVIE] && git[GIT_OVR];
    end
  end

  // Read multiplexer; unmapped offsets and empty pages read zero.
  always_comb begin
    next_rdData = '0;
    case (regAddr)
      REG_CTRL: next_rdData = ctrl;
      REG_GIT: next_rdData = git;
      REG_IE: next_rdData = {5'h00, irqEn};
      REG_SIT: next_rdData = {2'h0, sit};
      REG_HPP: next_rdData = {hpp[OBJ_W] ? {1'b0, hpp[OBJ_W-1:0]} : HPP_NONE,
                              4'h0};
      REG_PAGE: next_rdData = {page, aincOff, dataIdx};
      REG_TMR_L: next_rdData = timerVal[7:0];
      REG_TMR_H: next_rdData = timerVal[15:8];
      REG_PRESC: next_rdData = prescale;
      REG_TEC: next_rdData = tec[8] ? 8'hff : tec[7:0];
      REG_REC: next_rdData = rec[7:0];
      REG_ESTAT: next_rdData = {6'h00, fault == ERR_PASSIVE_ST,
                                fault == BUS_OFF};
      REG_SYNC_L: next_rdData = syncStamp[7:0];
      REG_SYNC_H: next_rdData = syncStamp[15:8];
      default: begin
        if (pageOk) begin
          case (regAddr)
            REG_STAT: next_rdData = {1'b0, stat[sel]};
            REG_DATA: next_rdData = dataBuf[sel][dataIdx];
            REG_STMP_L: next_rdData = stamp[sel][7:0];
            REG_STMP_H: next_rdData = stamp[sel][15:8];
            REG_OCFG: next_rdData = {7'h00, rxArm[sel]};
            default: begin
              if (regAddr[4:2] == REG_TAG0[4:2]) begin
                next_rdData = tag[sel][8*regAddr[1:0] +: 8];
              end else if (regAddr[4:2] == REG_MSK0[4:2]) begin
                next_rdData = mask[sel][8*regAddr[1:0] +: 8];
              end
            end
          endcase
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? next_rdData : '0;
    end
  end
endmodule : cfb_top

// >>> sim/cfb_assertions.sv
// Port-level checks for the CAN filter, buffer, timer and error block.
// Assumes it is bound onto cfb_top, one clock, active-low reset.
`timescale 1ns/100ps
module cfb_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWr,
  input wire cfb_pkg::cfb_bitmon_s bitMon,
  input wire logic crcMismatch,
  input wire logic formViolation,
  input wire logic otherErrorFrame,
  input wire logic ovfHandlerEntry,
  input wire logic errorFrameReq,
  input wire logic errorFramePassive,
  input wire logic busInhibit,
  input wire logic retryAllowed,
  input wire logic timerIrq
);
  import cfb_pkg::*;
  // One domain, so clock and reset are given once for every check.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  formFrame_a: assert property (
    (formViolation && !busInhibit) |=> errorFrameReq)
    else $error("no error frame after form fault");
  crcFrame_a: assert property (
    (crcMismatch && !bitMon.transmitting && !busInhibit) |=> errorFrameReq)
    else $error("no error frame after crc fault");
  foreignFrame_a: assert property (
    (otherErrorFrame && !busInhibit) |=> errorFrameReq)
    else $error("no echo of foreign error frame");
  frameCause_a: assert property (
    errorFrameReq |-> $past(crcMismatch || formViolation
      || otherErrorFrame || bitMon.strobe))
    else $error("error frame without a cause");
  stateOne_a: assert property (
    !(busInhibit && errorFramePassive))
    else $error("passive and bus off together");
  offQuiet_a: assert property (
    (busInhibit && $past(busInhibit)) |-> !errorFrameReq)
    else $error("error frame while bus off");
  offExit_a: assert property (
    $fell(busInhibit) |-> $past(regWr, 3))
    else $error("bus off left without a write");
  retryHold_a: assert property (
    $changed(retryAllowed) |-> ($past(regWr) || $past(regWr, 2)))
    else $error("retry mode changed without a write");
  ovfClear_a: assert property (
    ovfHandlerEntry |=> ##1 !timerIrq)
    else $error("overflow irq kept after handler entry");
endmodule : cfb_assertions

// >>> sim/cfb_node_model.sv
// Stand-in for the other nodes on the bus: hands over received frames.
// Assumes the block takes each link pulse at the rising clock edge.
`timescale 1ns/100ps
module cfb_node_model (
  input wire logic sys_clk,
  output logic rxIdValid,
  output cfb_pkg::cfb_tag_s rxTag,
  output logic rxByteValid,
  output logic [cfb_pkg::IDX_W-1:0] rxByteIdx,
  output logic [cfb_pkg::DATA_W-1:0] rxByte,
  output logic rxDone
);
  import cfb_pkg::*;
  // Idle link: no frame in flight.
  initial begin
    rxIdValid = 1'b0;
    rxTag = '0;
    rxByteValid = 1'b0;
    rxByteIdx = '0;
    rxByte = '0;
    rxDone = 1'b0;
  end
  // One whole standard frame of eight bytes, base plus position.
  task sendFrame(input logic [28:0] id, input logic [7:0] base);
    @(posedge sys_clk);
    rxIdValid <= 1'b1;
    rxTag <= {3'b000, id};
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      rxIdValid <= 1'b0;
      rxByteValid <= 1'b1;
      rxByteIdx <= 3'(i);
      rxByte <= base + 8'(i);
    end
    @(posedge sys_clk);
    rxByteValid <= 1'b0;
    rxDone <= 1'b1;
    rxByte <= ~rxByte; // Released byte and tag lines never keep the last value.
    rxTag <= ~rxTag;
    @(posedge sys_clk);
    rxDone <= 1'b0;
  endtask : sendFrame
endmodule : cfb_node_model

// >>> sim/testbench.sv
// Self-checking bench for the CAN filter, buffer, timer and error block.
// Assumes the node model supplies frames; software is this bench.
`timescale 1ns/100ps
module testbench;
  import cfb_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [4:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData, txByte;
  cfb_bitmon_s bitMon = '0;
  logic crcMismatch = 1'b0, formViolation = 1'b0, otherErrorFrame = 1'b0;
  logic txDone = 1'b0, sofSeen = 1'b0, eofSeen = 1'b0, bufferSetDone = 1'b0;
  logic ovfHandlerEntry = 1'b0, rxIdValid, rxByteValid, rxDone;
  logic [2:0] txObj = '0, txByteIdx = '0, rxByteIdx;
  logic [7:0] rxByte;
  cfb_tag_s rxTag;
  logic errorFrameReq, errorFramePassive, busInhibit, retryAllowed;
  logic canIrq, timerIrq;
  int fails = 0, nCompared = 0;
  cfb_top dut (.*);
  cfb_node_model node (.*);
  // Free-running 100 MHz clock.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe.
  task rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask : rd
  task cfgObj(input logic [7:0] pg, input logic [31:0] t, input logic [31:0] m);
    wr(REG_PAGE, pg);
    for (int k = 0; k < 4; k++) begin
      wr(REG_TAG0 + 5'(k), t[8*k +: 8]);
      wr(REG_MSK0 + 5'(k), m[8*k +: 8]);
    end
    wr(REG_OCFG, 8'h01);
  endtask : cfgObj
  task resetCheck;
    rd(REG_CTRL, 8'h00);
    rd(REG_ESTAT, 8'h00);
    chk({7'h00, retryAllowed}, 8'h01);
  endtask : resetCheck
  // Two reads 160 clocks apart at 16 clocks a tick differ by ten.
  task timerRun;
    wr(REG_PRESC, 8'h01);
    wr(REG_CTRL, 8'h09);
    rd(REG_TMR_L, 8'h00);
    repeat (158) @(posedge sys_clk);
    rd(REG_TMR_L, 8'h0a);
  endtask : timerRun
  task errors;
    @(posedge sys_clk);
    crcMismatch <= 1'b1;
    @(posedge sys_clk);
    crcMismatch <= 1'b0;
    formViolation <= 1'b1;
    @(posedge sys_clk);
    formViolation <= 1'b0;
    otherErrorFrame <= 1'b1;
    @(posedge sys_clk);
    otherErrorFrame <= 1'b0;
    rd(REG_GIT, 8'h60);
    rd(REG_REC, 8'h02);
    wr(REG_GIT, 8'h00);
    rd(REG_GIT, 8'h60);
    wr(REG_GIT, 8'h20);
    rd(REG_GIT, 8'h40);
    wr(REG_GIT, 8'h40);
    // a transmit bit error on object 0, then a transmit form fault that also flags a bit error.
    @(posedge sys_clk);
    bitMon <= cfb_bitmon_s'(8'hd0);
    @(posedge sys_clk);
    bitMon <= cfb_bitmon_s'(8'h10);
    formViolation <= 1'b1;
    @(posedge sys_clk);
    bitMon <= '0;
    formViolation <= 1'b0;
    wr(REG_PAGE, 8'h00);
    rd(REG_STAT, 8'h24);
    rd(REG_TEC, 8'h10);
    rd(REG_GIT, 8'h00);
  endtask : errors
  task filterRun;
    cfgObj(8'h10, 32'h310, 32'h7f8);
    cfgObj(8'h20, 32'h317, 32'h7ff);
    cfgObj(8'h50, 32'h000, 32'h000);
    wr(REG_IE, 8'h01);
    node.sendFrame(29'h317, 8'h10);
    node.sendFrame(29'h2a5, 8'h50);
    rd(REG_SIT, 8'h22);
    rd(REG_HPP, 8'h10);
    chk({7'h00, canIrq}, 8'h01);
    wr(REG_PAGE, 8'h20);
    rd(REG_STAT, 8'h00);
    wr(REG_PAGE, 8'h17);
    rd(REG_TAG0, 8'h17);
    rd(REG_DATA, 8'h17);
    rd(REG_DATA, 8'h10);
    wr(REG_PAGE, 8'h1a);
    rd(REG_DATA, 8'h12);
    rd(REG_DATA, 8'h12);
    wr(REG_PAGE, 8'h50);
    rd(REG_TAG0, 8'ha5);
    rd(REG_DATA, 8'h50);
    wr(REG_PAGE, 8'h60);
    rd(REG_STAT, 8'h00);
    wr(REG_PAGE, 8'h10);
    rd(REG_STAT, 8'h01);
    wr(REG_STAT, 8'h00);
    rd(REG_HPP, 8'h50);
    wr(REG_PAGE, 8'h50);
    wr(REG_STAT, 8'h00);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h00, canIrq}, 8'h00);
  endtask : filterRun
  // The timer restarts at one tick per 8 clocks, so stamps are known.
  task txRun;
    wr(REG_PRESC, 8'h00);
    wr(REG_CTRL, 8'h08);
    wr(REG_CTRL, 8'h09);
    repeat (20) @(posedge sys_clk);
    @(posedge sys_clk);
    txObj <= 3'h3;
    txDone <= 1'b1;
    sofSeen <= 1'b1;
    ovfHandlerEntry <= 1'b1;
    @(posedge sys_clk);
    txDone <= 1'b0;
    sofSeen <= 1'b0;
    ovfHandlerEntry <= 1'b0;
    txObj <= 3'h1;
    txByteIdx <= 3'h3;
    wr(REG_PAGE, 8'h30);
    rd(REG_STAT, 8'h02);
    rd(REG_STMP_L, 8'h02);
    chk(txByte, 8'h13);
    wr(REG_CTRL, 8'h0b);
    // Start of frame captures; a later end of frame must not.
    @(posedge sys_clk);
    sofSeen <= 1'b1;
    @(posedge sys_clk);
    sofSeen <= 1'b0;
    eofSeen <= 1'b1;
    @(posedge sys_clk);
    eofSeen <= 1'b0;
    rd(REG_SYNC_L, 8'h03);
    chk({7'h00, retryAllowed}, 8'h00);
  endtask : txRun
  task results;
    if (fails == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    resetCheck();
    timerRun();
    errors();
    filterRun();
    txRun();
    results();
  end
  // The whole run needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    results();
  end
endmodule : testbench
bind cfb_top cfb_assertions chk (.*);
